// ==== shared/vic_pkg.sv ====
// Constants, register map and types of the vectored priority interrupt controller
package vic_pkg;
    localparam int VIC_NSRC = 32;
    localparam int VIC_NLVL = 8;
    localparam logic [31:0] VIC_RSV_MASK = 32'h9FFF_0000; // 16-28 and the unused 31
    localparam logic [31:0] VIC_EXT_MASK = 32'h6000_0001;
    // Word offsets (byte address = offset)
    localparam logic [11:0] VIC_SMR0 = 12'h000; // 32 mode words: prio[2:0], type[6:5]
    localparam logic [11:0] VIC_SVR0 = 12'h080; // 32 vector words
    localparam logic [11:0] VIC_IVR = 12'h100;
    localparam logic [11:0] VIC_FVR = 12'h104;
    localparam logic [11:0] VIC_ISR = 12'h108;
    localparam logic [11:0] VIC_IPR = 12'h10C;
    localparam logic [11:0] VIC_IMR = 12'h110;
    localparam logic [11:0] VIC_CISR = 12'h114;
    localparam logic [11:0] VIC_IECR = 12'h120;
    localparam logic [11:0] VIC_IDCR = 12'h124;
    localparam logic [11:0] VIC_ICCR = 12'h128;
    localparam logic [11:0] VIC_ISCR = 12'h12C;
    localparam logic [11:0] VIC_EOICR = 12'h130;
    localparam logic [11:0] VIC_SPUR = 12'h134;
    localparam logic [11:0] VIC_DCR = 12'h138;
    localparam logic [11:0] VIC_FFER = 12'h140;
    localparam logic [11:0] VIC_FFDR = 12'h144;
    localparam logic [11:0] VIC_FFSR = 12'h148;
    localparam int VIC_PRIO_LSB = 0;
    localparam int VIC_TYPE_LSB = 5;
    localparam int VIC_DCR_PROT = 0;
    localparam int VIC_DCR_GMSK = 1;
    localparam logic [31:0] VIC_SPUR_RST = 32'h0000_0000;
    // Trigger types: internal uses bit 0 only (edge when set)
    localparam logic [1:0] VIC_T_LOW = 2'h0;
    localparam logic [1:0] VIC_T_FALL = 2'h1;
    localparam logic [1:0] VIC_T_HIGH = 2'h2;
    localparam logic [1:0] VIC_T_RISE = 2'h3;
endpackage

// ==== shared/vic_det_if.sv ====
// Interface between controller core and per-source detector
`timescale 1ns/10ps
interface vic_det_if;
    logic [1:0] mode;
    logic is_ext;
    logic clr;
    logic set;
    logic pend;
    modport core (output mode, output is_ext, output clr, output set, input pend);
    modport det (input mode, input is_ext, input clr, input set, output pend);
endinterface

// ==== rtl/vic_det.sv ====
// One source's trigger detector and pending flag
`timescale 1ns/10ps
module vic_det
    import vic_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic src,
    vic_det_if.det d
);
    logic prev_ff;
    logic lvl;
    logic edge_mode;
    logic hit;
    logic pend_ff;

    // Polarity applied before detection; internal sources are active high
    assign lvl = (d.is_ext && !d.mode[1]) ? ~src : src;
    assign edge_mode = d.mode[0];
    assign hit = edge_mode ? (lvl && !prev_ff) : lvl;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            prev_ff <= 1'b0;
        end else begin
            prev_ff <= lvl;
        end
    end

    // Edge pending is sticky; a new edge wins over a clear in the same cycle
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pend_ff <= 1'b0;
        end else if (!edge_mode) begin
            pend_ff <= lvl;
        end else if (hit || d.set) begin
            pend_ff <= 1'b1;
        end else if (d.clr) begin
            pend_ff <= 1'b0;
        end
    end
    assign d.pend = pend_ff;
endmodule // vic_det

// ==== rtl/vic_ctrl.sv ====
// Vectored priority interrupt controller with APB register access
`timescale 1ns/10ps
module vic_ctrl
    import vic_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic fast_int_input,
    input wire logic system_periph_source,
    input wire logic [13:0] periph_int,
    input wire logic ext_int_pin_a,
    input wire logic ext_int_pin_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic normal_int_req_n,
    output logic fast_int_req_n
);
    // ****************************************************************
    // Storage
    // ****************************************************************
    logic [31:0] src_vec;
    logic [31:0] pend;
    logic [31:0] det_clr;
    logic [31:0] det_set;
    logic [31:0] enab_ff;
    logic [31:0] ffrc_ff;
    logic [2:0] prio_ff [VIC_NSRC];
    logic [1:0] type_ff [VIC_NSRC];
    logic [31:0] svr_ff [VIC_NSRC];
    logic [31:0] spur_ff;
    logic prot_ff;
    logic gmsk_ff;
    logic [31:0] prdata_ff;
    // Service stack: one entry per level, bit set = level in service
    logic [VIC_NLVL-1:0] stk_ff;
    logic [4:0] stk_src_ff [VIC_NLVL];
    logic [4:0] cur_ff;
    logic cur_valid_ff;
    logic [4:0] cur_isr_ff;

    // Source line assembly, reserved numbers tied inactive
    assign src_vec = {1'b0, ext_int_pin_b, ext_int_pin_a, 13'h0000,
                      periph_int, system_periph_source, fast_int_input};

    // ****************************************************************
    // Per-source detectors
    // ****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < VIC_NSRC; gi++) begin : g_src
            vic_det_if dif ();
            assign dif.mode = type_ff[gi];
            assign dif.is_ext = VIC_EXT_MASK[gi];
            assign dif.clr = det_clr[gi];
            assign dif.set = det_set[gi];
            assign pend[gi] = dif.pend & ~VIC_RSV_MASK[gi];
            vic_det u_det (
                .mclk(mclk),
                .arst_n(arst_n),
                .src(src_vec[gi]),
                .d(dif.det)
            );
        end
    endgenerate

    // ****************************************************************
    // Priority resolution
    // ****************************************************************
    logic [31:0] norm_cand;
    logic [31:0] fast_cand;
    logic [4:0] best_src;
    logic [2:0] best_pri;
    logic best_ok;
    logic [2:0] cur_lvl;
    logic in_srv;

    assign norm_cand = pend & enab_ff & ~ffrc_ff & 32'hFFFF_FFFE;
    assign fast_cand = pend & enab_ff & (ffrc_ff | 32'h0000_0001);
    assign in_srv = |stk_ff;

    // Highest priority wins, lowest number breaks ties
    always_comb begin
        best_src = 5'h00;
        best_pri = 3'h0;
        best_ok = 1'b0;
        for (int i = VIC_NSRC - 1; i >= 0; i--) begin
            if (norm_cand[i] && (!best_ok || prio_ff[i] >= best_pri)) begin
                best_src = 5'(i);
                best_pri = prio_ff[i];
                best_ok = 1'b1;
            end
        end
    end

    always_comb begin
        cur_lvl = 3'h0;
        for (int i = 0; i < VIC_NLVL; i++) begin
            if (stk_ff[i]) begin
                cur_lvl = 3'(i);
            end
        end
    end

    // Request only when strictly above the level in service
    logic irq_want;
    assign irq_want = best_ok && (!in_srv || best_pri > cur_lvl);

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            normal_int_req_n <= 1'b1;
            fast_int_req_n <= 1'b1;
        end else begin
            normal_int_req_n <= ~(irq_want && !gmsk_ff);
            fast_int_req_n <= ~((|fast_cand) && !gmsk_ff);
        end
    end

    // ****************************************************************
    // APB slave
    // ****************************************************************
    logic wr;
    logic rd;
    logic [4:0] widx;
    logic ivr_rd;
    logic eoi_wr;
    logic ivr_auto;
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign widx = paddr[6:2];
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign ivr_rd = rd && paddr == VIC_IVR;
    assign eoi_wr = wr && paddr == VIC_EOICR;
    // Protect mode: a vector read has no side effect, a write does instead
    assign ivr_auto = prot_ff ? (wr && paddr == VIC_IVR) : ivr_rd;

    // Mode and vector words
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < VIC_NSRC; i++) begin
                prio_ff[i] <= 3'h0;
                type_ff[i] <= VIC_T_LOW;
                svr_ff[i] <= 32'h0000_0000;
            end
        end else if (wr && paddr[11:7] == VIC_SMR0[11:7]) begin
            prio_ff[widx] <= pwdata[VIC_PRIO_LSB +: 3];
            type_ff[widx] <= pwdata[VIC_TYPE_LSB +: 2];
        end else if (wr && paddr[11:7] == VIC_SVR0[11:7]) begin
            svr_ff[widx] <= pwdata;
        end
    end

    // Enable, fast forcing, spurious vector and debug control
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            enab_ff <= 32'h0000_0000;
            ffrc_ff <= 32'h0000_0000;
            spur_ff <= VIC_SPUR_RST;
            prot_ff <= 1'b0;
            gmsk_ff <= 1'b0;
        end else if (wr) begin
            unique case (paddr)
                VIC_IECR: enab_ff <= enab_ff | (pwdata & ~VIC_RSV_MASK);
                VIC_IDCR: enab_ff <= enab_ff & ~pwdata;
                VIC_FFER: ffrc_ff <= ffrc_ff | (pwdata & 32'hFFFF_FFFE);
                VIC_FFDR: ffrc_ff <= ffrc_ff & ~pwdata;
                VIC_SPUR: spur_ff <= pwdata;
                VIC_DCR: begin
                    prot_ff <= pwdata[VIC_DCR_PROT];
                    gmsk_ff <= pwdata[VIC_DCR_GMSK];
                end
                default: ;
            endcase
        end
    end

    // Software set and clear of edge pending, and automatic clears
    always_comb begin
        det_set = 32'h0000_0000;
        det_clr = 32'h0000_0000;
        if (wr && paddr == VIC_ISCR) begin
            det_set = pwdata & ~VIC_RSV_MASK;
        end
        if (wr && paddr == VIC_ICCR) begin
            det_clr = pwdata;
        end
        if (ivr_auto && best_ok) begin
            det_clr[best_src] = 1'b1;
        end
        if (rd && paddr == VIC_FVR && !prot_ff) begin
            det_clr[0] = 1'b1;
        end
    end

    // Next level down in service, so a pop restores the source it interrupted
    logic [2:0] prev_lvl;
    logic prev_ok;
    always_comb begin
        prev_lvl = 3'h0;
        prev_ok = 1'b0;
        for (int i = 0; i < VIC_NLVL; i++) begin
            if (stk_ff[i] && 3'(i) != cur_lvl) begin
                prev_lvl = 3'(i);
                prev_ok = 1'b1;
            end
        end
    end

    // Service stack: vector read (vector write in protect mode) pushes, end-of-interrupt pops
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            stk_ff <= '0;
            cur_valid_ff <= 1'b0;
            cur_isr_ff <= 5'h00;
            for (int i = 0; i < VIC_NLVL; i++) begin
                stk_src_ff[i] <= 5'h00;
            end
        end else if (ivr_auto && irq_want) begin
            stk_ff[best_pri] <= 1'b1;
            stk_src_ff[best_pri] <= best_src;
            cur_isr_ff <= best_src;
            cur_valid_ff <= 1'b1;
        end else if (eoi_wr && in_srv) begin
            stk_ff[cur_lvl] <= 1'b0;
            cur_isr_ff <= prev_ok ? stk_src_ff[prev_lvl] : 5'h00;
            cur_valid_ff <= prev_ok;
        end
    end

    // Registered read data
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            prdata_ff <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            if (paddr[11:7] == VIC_SMR0[11:7]) begin
                prdata_ff <= 32'({type_ff[paddr[6:2]], 2'b00, prio_ff[paddr[6:2]]});
            end else if (paddr[11:7] == VIC_SVR0[11:7]) begin
                prdata_ff <= svr_ff[paddr[6:2]];
            end else begin
                unique case (paddr)
                    VIC_IVR: prdata_ff <= irq_want ? svr_ff[best_src] : spur_ff;
                    VIC_FVR: prdata_ff <= fast_cand[0] ? svr_ff[0] : spur_ff;
                    VIC_ISR: prdata_ff <= cur_valid_ff ? 32'(cur_isr_ff) : 32'h0000_0000;
                    VIC_IPR: prdata_ff <= pend;
                    VIC_IMR: prdata_ff <= enab_ff;
                    VIC_CISR: prdata_ff <= {30'h0000_0000, ~normal_int_req_n, ~fast_int_req_n};
                    VIC_SPUR: prdata_ff <= spur_ff;
                    VIC_DCR: prdata_ff <= {30'h0000_0000, gmsk_ff, prot_ff};
                    VIC_FFSR: prdata_ff <= ffrc_ff;
                    default: prdata_ff <= 32'h0000_0000;
                endcase
            end
        end
    end
    assign prdata = prdata_ff;
endmodule // vic_ctrl

// ==== dv/vic_ctrl_monitor.sv ====
// Checker of bus answers and request lines of the interrupt controller
`timescale 1ns/10ps
module vic_ctrl_monitor
    import vic_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic normal_int_req_n,
    input wire logic fast_int_req_n
);
    // ****************
    // Shadow of bus-written state
    // ****************
    logic [31:0] en_ff, ff_ff, spur_ff;
    logic gm_ff;
    logic [3:0] cond;
    logic [3:0][1:0] cnt_ff;
    logic wr_acc;
    assign wr_acc = psel && penable && pwrite && pready;
    // Only writable enable bits are tracked, so reserved sources stay off here
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            en_ff <= '0;
            ff_ff <= '0;
            gm_ff <= 1'b0;
            spur_ff <= VIC_SPUR_RST;
        end else if (wr_acc) begin
            if (paddr == VIC_IECR) en_ff <= en_ff | (pwdata & 32'h6000_FFFF);
            if (paddr == VIC_IDCR) en_ff <= en_ff & ~pwdata;
            if (paddr == VIC_FFER) ff_ff <= ff_ff | pwdata;
            if (paddr == VIC_FFDR) ff_ff <= ff_ff & ~pwdata;
            if (paddr == VIC_DCR) gm_ff <= pwdata[VIC_DCR_GMSK];
            if (paddr == VIC_SPUR) spur_ff <= pwdata;
        end
    end
    // Saturating age of each quiet condition; 3 leaves room for the 2-cycle path
    assign cond = {(en_ff & ~ff_ff & 32'hFFFF_FFFE) == 32'h0,
                   !en_ff[0] && ((en_ff & ff_ff) == 32'h0), en_ff == 32'h0, gm_ff};
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_ff <= '0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                cnt_ff[i] <= !cond[i] ? 2'h0 : (cnt_ff[i] == 2'h3 ? 2'h3 : cnt_ff[i] + 2'h1);
            end
        end
    end
    // ****************
    // Assertions
    // ****************
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    chk_reset_idle: assert property (
        $rose(arst_n) |-> normal_int_req_n && fast_int_req_n && prdata == 32'h0)
        else $error("request or read data active after reset");
    chk_bus_answer: assert property (
        psel && penable |-> pready && !pslverr) else $error("bus access not answered");
    chk_rdata_hold: assert property (
        psel && penable |=> $stable(prdata)) else $error("read data moved after access");
    chk_mask_both: assert property (
        cnt_ff[0] == 2'h3 |-> normal_int_req_n && fast_int_req_n)
        else $error("request under general mask");
    chk_all_off: assert property (
        cnt_ff[1] == 2'h3 |-> normal_int_req_n && fast_int_req_n)
        else $error("request with no source enabled");
    chk_fast_cause: assert property (
        cnt_ff[2] == 2'h3 |-> fast_int_req_n) else $error("fast request without cause");
    chk_normal_cause: assert property (
        cnt_ff[3] == 2'h3 |-> normal_int_req_n) else $error("normal request without cause");
    chk_spur_idle: assert property (
        psel && !penable && !pwrite && paddr == VIC_IVR && cnt_ff[1] == 2'h3
        |=> prdata == spur_ff) else $error("idle vector read not spurious");
endmodule // vic_ctrl_monitor

bind vic_ctrl vic_ctrl_monitor mon_u (.mclk(mclk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .normal_int_req_n(normal_int_req_n),
    .fast_int_req_n(fast_int_req_n));

// ==== dv/vic_core_model.sv ====
// Processor core model that takes the two request lines
`timescale 1ns/10ps
module vic_core_model (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic normal_int_req_n,
    input wire logic fast_int_req_n,
    output logic [31:0] irq_cnt,
    output logic [31:0] fast_cnt
);
    logic irq_ff, fast_ff;
    // Count each new request; a held level is one request, not many
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            {irq_cnt, fast_cnt, irq_ff, fast_ff} <= {64'h0, 2'h3};
        end else begin
            irq_ff <= normal_int_req_n;
            fast_ff <= fast_int_req_n;
            if (irq_ff && !normal_int_req_n) irq_cnt <= irq_cnt + 1;
            if (fast_ff && !fast_int_req_n) fast_cnt <= fast_cnt + 1;
        end
    end
endmodule // vic_core_model

// ==== dv/tb_top.sv ====
// Self-checking bench of the vectored interrupt controller
`timescale 1ns/10ps
module tb_top
    import vic_pkg::*;
;
    logic mclk, arst_n, fast_in, sys_in, pin_a, pin_b, psel, penable, pwrite;
    logic pready, pslverr, irq_n, fast_n;
    logic [13:0] per_in;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_v, spur_m, irq_cnt, fast_cnt;
    logic [31:0] vec_m[32];
    logic [15:0] lf;
    int prio_m[32];
    int num_errors, num_checks;
    vic_ctrl dut_u (.mclk(mclk), .arst_n(arst_n), .fast_int_input(fast_in),
        .system_periph_source(sys_in), .periph_int(per_in), .ext_int_pin_a(pin_a),
        .ext_int_pin_b(pin_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .normal_int_req_n(irq_n), .fast_int_req_n(fast_n));
    vic_core_model core_u (.mclk(mclk), .arst_n(arst_n), .normal_int_req_n(irq_n),
        .fast_int_req_n(fast_n), .irq_cnt(irq_cnt), .fast_cnt(fast_cnt));
    // ****************
    // Helpers
    // ****************
    always #5 mclk = ~mclk;
    function automatic logic [15:0] step(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    // Highest level wins; scanning downward lets the lower number win a tie
    function automatic int best(input logic [31:0] p);
        int b = 0;
        for (int s = 31; s >= 1; s--) if (p[s] && prio_m[s] >= prio_m[b]) b = s;
        return b;
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One transfer; the wait for pready is cut only by the watchdog
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd_v = prdata;
        {psel, penable} <= 2'b00;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, rd_v, exp);
    endtask
    task automatic mode(input int s, input logic [1:0] t, input int p);
        prio_m[s] = p;
        wr(VIC_SMR0 + 12'(4 * s), {25'h0, t, 2'h0, 3'(p)});
    endtask
    task automatic settle;
        repeat (3) @(posedge mclk);
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        #100us;
        num_errors++;
        print_verdict;
    end
    // ****************
    // Tests
    // ****************
    initial begin
        logic act;
        logic [31:0] c0;
        {mclk, arst_n, sys_in, psel, penable, pwrite, per_in, paddr, pwdata} = '0;
        {fast_in, pin_a, pin_b, lf, num_errors, num_checks} = {3'h7, 16'h0055, 64'h0};
        foreach (prio_m[s]) prio_m[s] = 0;
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        rd(VIC_IMR, 32'h0, "imr");
        rd(VIC_IVR, VIC_SPUR_RST, "ivr idle");
        wr(12'h3F0, 32'hFFFF_FFFF);
        rd(12'h3F0, 32'h0, "unmapped");
        for (int s = 0; s < 32; s++) begin
            lf = step(lf);
            vec_m[s] = {lf, ~lf};
            wr(VIC_SVR0 + 12'(4 * s), vec_m[s]);
        end
        for (int s = 0; s < 32; s++) rd(VIC_SVR0 + 12'(4 * s), vec_m[s], "vector");
        wr(VIC_ISCR, 32'h9FFF_0000);
        wr(VIC_IECR, 32'hFFFF_FFFF);
        rd(VIC_IMR, 32'h6000_FFFF, "imr all");
        rd(VIC_IPR, 32'h0, "ipr reserved");
        wr(VIC_IDCR, 32'hFFFF_FFFF);
        $display("test registers finished");
        lf = step(lf);
        spur_m = {~lf, lf};
        wr(VIC_SPUR, spur_m);
        mode(2, VIC_T_HIGH, 1);
        mode(5, VIC_T_HIGH, 6);
        mode(1, VIC_T_HIGH, 7);
        wr(VIC_IECR, 32'h0000_0026);
        c0 = irq_cnt;
        @(posedge mclk);
        per_in <= 14'h0009;
        settle;
        chk("irq", irq_n, 1'b0);
        rd(VIC_IVR, vec_m[best(32'h24)], "ivr prio");
        settle;
        chk("irq lower", irq_n, 1'b1);
        @(posedge mclk);
        sys_in <= 1'b1;
        settle;
        rd(VIC_IVR, vec_m[best(32'h26)], "ivr nest");
        chk("irq count", irq_cnt - c0, 32'h2);
        wr(VIC_EOICR, 32'h0);
        wr(VIC_EOICR, 32'h0);
        @(posedge mclk);
        {sys_in, per_in} <= '0;
        settle;
        rd(VIC_IVR, spur_m, "ivr gone");
        wr(VIC_IDCR, 32'hFFFF_FFFF);
        settle;
        rd(VIC_IVR, spur_m, "ivr none");
        $display("test priority finished");
        for (int t = 0; t < 4; t++) begin
            act = (t >= 2);
            @(posedge mclk);
            pin_a <= ~act;
            mode(29, 2'(t), 3);
            settle;
            wr(VIC_ICCR, 32'h2000_0000);
            rd(VIC_IPR, 32'h0, "ext idle");
            @(posedge mclk);
            pin_a <= act;
            settle;
            rd(VIC_IPR, 32'h2000_0000, "ext active");
            @(posedge mclk);
            pin_a <= ~act;
            settle;
            rd(VIC_IPR, t[0] ? 32'h2000_0000 : 32'h0, "ext back");
        end
        wr(VIC_ICCR, 32'h2000_0000);
        mode(3, VIC_T_RISE, 2);
        @(posedge mclk);
        per_in <= 14'h0002;
        @(posedge mclk);
        per_in <= 14'h0000;
        settle;
        rd(VIC_IPR, 32'h0000_0008, "int edge");
        wr(VIC_IECR, 32'h0000_0008);
        wr(VIC_DCR, 32'h1);
        rd(VIC_IVR, vec_m[3], "ivr protect");
        rd(VIC_IPR, 32'h0000_0008, "protect keeps");
        // In protect mode a vector write takes over the read's side effects
        wr(VIC_IVR, 32'h0);
        rd(VIC_IPR, 32'h0, "protect write");
        wr(VIC_EOICR, 32'h0);
        wr(VIC_ISCR, 32'h0000_0008);
        rd(VIC_IPR, 32'h0000_0008, "soft set");
        wr(VIC_DCR, 32'h0);
        rd(VIC_IVR, vec_m[3], "ivr open");
        rd(VIC_IPR, 32'h0, "open clears");
        wr(VIC_EOICR, 32'h0);
        wr(VIC_IDCR, 32'hFFFF_FFFF);
        $display("test triggers finished");
        @(posedge mclk);
        fast_in <= 1'b0;
        mode(0, VIC_T_HIGH, 0);
        mode(30, VIC_T_LOW, 4);
        // Bit 0 is always fast and cannot be forced
        wr(VIC_FFER, 32'h4000_0001);
        rd(VIC_FFSR, 32'h4000_0000, "force status");
        wr(VIC_IECR, 32'h4000_0001);
        c0 = fast_cnt;
        @(posedge mclk);
        pin_b <= 1'b0;
        settle;
        chk("fast forced", fast_n, 1'b0);
        chk("irq forced", irq_n, 1'b1);
        @(posedge mclk);
        {pin_b, fast_in} <= 2'b11;
        settle;
        chk("fast src0", fast_n, 1'b0);
        chk("fast count", fast_cnt - c0, 32'h1);
        wr(VIC_FFDR, 32'hFFFF_FFFF);
        wr(VIC_IECR, 32'h0000_0004);
        wr(VIC_DCR, 32'h2);
        @(posedge mclk);
        per_in <= 14'h0001;
        settle;
        chk("mask irq", irq_n, 1'b1);
        chk("mask fast", fast_n, 1'b1);
        rd(VIC_IPR, 32'h0000_0005, "mask pending");
        wr(VIC_DCR, 32'h0);
        settle;
        chk("unmask irq", irq_n, 1'b0);
        chk("unmask fast", fast_n, 1'b0);
        rd(VIC_CISR, 32'h0000_0003, "both lines");
        $display("test fast and mask finished");
        print_verdict;
    end
endmodule // tb_top
